// [rtl/dwb_ctl.sv]
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dwb_consts.svh"
module dwb_ctl import dwb_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int LANES = 1,
  parameter int DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  dwb_link_if.ctl link
);
  localparam int FW = DQ_W + LANES;
  localparam logic [2:0] HALF_M1 = 3'(`DWB_HALF_CYC - 1);
  logic [31:0] cfg_r;
  logic [13:0] cmd_a_r;
  logic [1:0] cmd_ba_r;
  logic pend_r;
  logic err_r;
  logic [2:0] div_r;
  logic ck_r;
  logic [5:0] cnt_r;
  logic [3:0] beat_r;
  dwb_ctl_state_type st_r;
  logic req, is_dat, acc, wr_do, full_sel, tick, violate, pop_now;
  logic fifo_rdy, fifo_vld;
  logic [FW-1:0] fifo_q;
  logic [4:0] fifo_cnt;
  logic [1:0] bl;
  logic [5:0] wl, ccd;
  logic [3:0] len, cal;
  // config fields and per-command burst length
  assign bl = cfg_r[`DWB_CFG_BL +: 2];
  assign wl = 6'(cfg_r[`DWB_CFG_AL +: 5]) + 6'(cfg_r[`DWB_CFG_CWL +: 4]);
  assign cal = cfg_r[`DWB_CFG_CAL +: 4];
  assign len = (bl == `DWB_BL_CHOP4 || (bl == `DWB_BL_OTF && !cmd_a_r[`DWB_A12])) ?
    `DWB_BEATS_CHOP : `DWB_BEATS_FULL;
  assign ccd = cfg_r[`DWB_CFG_PRE2] ? `DWB_CCD_2T : `DWB_CCD_1T;
  // illegal settings refuse the command
  assign violate = (cfg_r[`DWB_CFG_PRE2] && cfg_r[`DWB_CFG_CWL +: 4] <= `DWB_CWL_MIN)
    || (cfg_r[`DWB_CFG_MASK] && cfg_r[`DWB_CFG_INV]);
  // bus slave decode; data writes stall while the fifo is full
  assign full_sel = i_wb_sel == 4'hf;
  assign req = i_wb_cyc & i_wb_stb & !o_wb_ack;
  assign is_dat = req & i_wb_we & (i_wb_adr == `DWB_OFS_DAT);
  assign acc = req & (!is_dat | fifo_rdy);
  assign wr_do = acc & i_wb_we & full_sel;
  assign tick = (div_r == HALF_M1) & ck_r;
  assign pop_now = tick & ((st_r == dwb_c_lat && cnt_r + 6'h01 == wl) ||
    (st_r == dwb_c_data && beat_r != len));
  dwb_fifo #(.W(FW), .DEPTH(DEPTH), .AW(4)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(is_dat & full_sel),
    .o_in_ready(fifo_rdy),
    .i_in_data({i_wb_dat[`DWB_DAT_KEEP +: LANES], i_wb_dat[DQ_W-1:0]}),
    .o_out_valid(fifo_vld),
    .i_out_ready(pop_now),
    .o_out_data(fifo_q),
    .o_count(fifo_cnt)
  );
  // acknowledge and read data
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= acc;
      if (acc) begin
        case (i_wb_adr)
          `DWB_OFS_CFG: o_wb_dat <= cfg_r;
          `DWB_OFS_STAT: o_wb_dat <= {19'h0, fifo_cnt, 6'h0, err_r, pend_r | (st_r != dwb_c_idle)};
          default: o_wb_dat <= '0;
        endcase
      end
    end
  end
  // config, pending command and sticky error; set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= `DWB_CFG_RST;
      cmd_a_r <= '0;
      cmd_ba_r <= '0;
      pend_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wr_do && i_wb_adr == `DWB_OFS_CFG) cfg_r <= i_wb_dat;
      if (wr_do && i_wb_adr == `DWB_OFS_STAT && i_wb_dat[`DWB_ST_ERR]) err_r <= 1'b0;
      if (wr_do && i_wb_adr == `DWB_OFS_CMD && !pend_r && st_r == dwb_c_idle) begin
        if (violate) begin
          err_r <= 1'b1;
        end else begin
          pend_r <= 1'b1;
          cmd_a_r <= i_wb_dat[13:0];
          cmd_ba_r <= i_wb_dat[`DWB_CMD_BANK +: 2];
        end
      end
      if (tick && st_r == dwb_c_idle && pend_r && fifo_cnt >= 5'(len)) pend_r <= 1'b0;
    end
  end
  // link clock divider
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_r <= '0;
      ck_r <= 1'b0;
    end else begin
      div_r <= (div_r == HALF_M1) ? 3'h0 : div_r + 3'h1;
      if (div_r == HALF_M1) ck_r <= !ck_r;
    end
  end
  // link engine; every change lands on a falling link clock edge
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= dwb_c_idle;
      cnt_r <= '0;
      beat_r <= '0;
      link.cs_n <= 1'b1;
      link.wr_n <= 1'b1;
      link.die_term <= 1'b0;
      link.dqs <= 1'b0;
      link.a <= '0;
      link.ba <= '0;
      link.dq <= '0;
      link.dm_n <= '1;
    end else if (tick) begin
      case (st_r)
        dwb_c_idle: begin
          if (pend_r && fifo_cnt >= 5'(len)) begin
            link.cs_n <= 1'b0;
            cnt_r <= '0;
            if (cal == 4'h0) begin
              link.wr_n <= 1'b0;
              link.die_term <= 1'b1;
              link.a <= cmd_a_r;
              link.ba <= cmd_ba_r;
              st_r <= dwb_c_lat;
            end else begin
              st_r <= dwb_c_sel;
            end
          end
        end
        dwb_c_sel: begin
          link.cs_n <= 1'b1;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r + 6'h01 == 6'(cal)) begin
            link.wr_n <= 1'b0;
            link.die_term <= 1'b1;
            link.a <= cmd_a_r;
            link.ba <= cmd_ba_r;
            cnt_r <= '0;
            st_r <= dwb_c_lat;
          end
        end
        dwb_c_lat: begin
          link.cs_n <= 1'b1;
          link.wr_n <= 1'b1;
          link.die_term <= 1'b0;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r + 6'h01 == wl) begin
            link.dqs <= 1'b1;
            {link.dm_n, link.dq} <= fifo_q;
            beat_r <= 4'h1;
            st_r <= dwb_c_data;
          end
        end
        dwb_c_data: begin
          if (beat_r == len) begin
            link.dqs <= 1'b0;
            cnt_r <= '0;
            st_r <= dwb_c_rec;
          end else begin
            {link.dm_n, link.dq} <= fifo_q;
            beat_r <= beat_r + 4'h1;
          end
        end
        dwb_c_rec: begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r + 6'h01 >= `DWB_WR_REC && cnt_r + 6'h01 >= ccd) st_r <= dwb_c_idle;
        end
        default: st_r <= dwb_c_idle;
      endcase
    end
  end
  assign link.ck = ck_r;
endmodule
`default_nettype wire

// [rtl/dwb_consts.svh]
`ifndef DWB_CONSTS_SVH
`define DWB_CONSTS_SVH
// burst-length field codes
`define DWB_BL_FIXED8 2'b00
`define DWB_BL_OTF 2'b01
`define DWB_BL_CHOP4 2'b10
// address bits with a command meaning
`define DWB_A10 10
`define DWB_A12 12
`define DWB_BEATS_FULL 4'h8
`define DWB_BEATS_CHOP 4'h4
`define DWB_LAST_SLOT 6'h07
`define DWB_CWL_MIN 4'h9
// link clock timing
`define DWB_SYS_NS 20
`define DWB_CK_NS 160
`define DWB_HALF_CYC (`DWB_CK_NS / (2 * `DWB_SYS_NS))
`define DWB_WR_REC 6'h08
`define DWB_CCD_1T 6'h05
`define DWB_CCD_2T 6'h06
// controller register offsets
`define DWB_OFS_CFG 8'h00
`define DWB_OFS_CMD 8'h04
`define DWB_OFS_DAT 8'h08
`define DWB_OFS_STAT 8'h0c
// config fields
`define DWB_CFG_BL 0
`define DWB_CFG_MASK 2
`define DWB_CFG_INV 3
`define DWB_CFG_CRC 4
`define DWB_CFG_PRE2 5
`define DWB_CFG_CWL 8
`define DWB_CFG_AL 12
`define DWB_CFG_CAL 20
`define DWB_CFG_RST 32'h0000_0a00
`define DWB_CMD_BANK 16
`define DWB_DAT_KEEP 8
`define DWB_ST_BUSY 0
`define DWB_ST_ERR 1
`define DWB_ST_CNT 8
`endif

// [rtl/dwb_pkg.sv]
`include "dwb_consts.svh"
package dwb_pkg;
  typedef enum logic [0:0] {
    dwb_d_idle = 1'b0,
    dwb_d_burst = 1'b1
  } dwb_dev_state_type;
  typedef enum logic [2:0] {
    dwb_c_idle = 3'b000,
    dwb_c_sel = 3'b001,
    dwb_c_lat = 3'b010,
    dwb_c_data = 3'b011,
    dwb_c_rec = 3'b100
  } dwb_ctl_state_type;
endpackage

// [rtl/dwb_if.sv]
`timescale 1ns/10ps
`default_nettype none
// one-way write link from controller to memory device
interface dwb_link_if #(parameter int DQ_W = 8, parameter int LANES = 1);
  logic ck;
  logic cs_n;
  logic wr_n;
  logic die_term;
  logic dqs;
  logic [13:0] a;
  logic [1:0] ba;
  logic [DQ_W-1:0] dq;
  logic [LANES-1:0] dm_n;
  modport ctl(output ck, cs_n, wr_n, die_term, dqs, a, ba, dq, dm_n);
  modport dram(input ck, cs_n, wr_n, die_term, dqs, a, ba, dq, dm_n);
endinterface
`default_nettype wire

// [rtl/dwb_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module dwb_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [AW:0] o_count
);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  // depth must be a power of two so the pointers wrap by themselves
  assign o_in_ready = cnt_r != (AW+1)'(DEPTH); // full only at DEPTH words
  assign o_out_valid = cnt_r != '0;
  assign o_out_data = mem_r[rp_r];
  assign o_count = cnt_r;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  // storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [rtl/dwb_dram.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dwb_consts.svh"
module dwb_dram import dwb_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int LANES = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  dwb_link_if.dram link,
  input wire logic [1:0] i_burst_mode,
  input wire logic [3:0] i_column_write_latency,
  input wire logic [4:0] i_additive_latency,
  input wire logic [3:0] i_cmd_latency,
  input wire logic i_mask_enable,
  input wire logic i_bus_inversion,
  input wire logic i_crc_enable,
  input wire logic i_dll_locked,
  output logic o_wr_valid,
  output logic [1:0] o_wr_bank,
  output logic [9:0] o_wr_col,
  output logic [DQ_W-1:0] o_wr_data,
  output logic [LANES-1:0] o_wr_lane_en,
  output logic o_precharge,
  output logic [1:0] o_precharge_bank,
  output logic [3:0] o_bank_open,
  output logic o_burst_chop,
  output logic o_mask_active,
  output logic o_crc_active,
  output logic o_crc_persistent,
  output logic o_die_term,
  output logic o_busy
);
  localparam int SW = 5 + 14 + 2 + DQ_W + LANES;
  localparam logic MASK_OK = (DQ_W == 8) || (DQ_W == 16);
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic ck_d_r;
  logic s_ck, s_cs_n, s_wr_n, s_term, s_dqs;
  logic [13:0] s_a;
  logic [1:0] s_ba;
  logic [DQ_W-1:0] s_dq;
  logic [LANES-1:0] s_dm_n;
  logic rise;
  logic [7:0] cs_hist_r;
  logic sel_hit;
  logic cmd_hit;
  logic chop_now;
  logic mask_on;
  dwb_dev_state_type st_r;
  logic [5:0] cnt_r;
  logic [5:0] wl_r;
  logic [5:0] slot;
  logic [1:0] bank_r;
  logic [9:0] col_r;
  logic ap_r;
  logic chop_r;
  logic [3:0] beats;

  // two-stage synchroniser for every link pin
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      ck_d_r <= 1'b0;
    end else begin
      s1_r <= {link.ck, link.cs_n, link.wr_n, link.die_term, link.dqs,
               link.a, link.ba, link.dq, link.dm_n};
      s2_r <= s1_r;
      ck_d_r <= s_ck;
    end
  end
  assign {s_ck, s_cs_n, s_wr_n, s_term, s_dqs, s_a, s_ba, s_dq, s_dm_n} = s2_r;

  // one-cycle pulse per rising link clock edge
  assign rise = s_ck & !ck_d_r;

  // chip-select history, one bit per link edge
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_hist_r <= '0;
    end else if (rise) begin
      cs_hist_r <= {cs_hist_r[6:0], !s_cs_n};
    end
  end

  // select seen the programmed number of edges earlier
  always_comb begin
    sel_hit = 1'b0;
    if (i_cmd_latency == 4'h0) begin
      sel_hit = !s_cs_n;
    end else if (i_cmd_latency <= 4'h8) begin
      sel_hit = cs_hist_r[3'(i_cmd_latency - 4'h1)];
    end
  end

  // commands only decoded while the delay loop is locked
  assign cmd_hit = rise & sel_hit & !s_wr_n & i_dll_locked &
    (st_r == dwb_d_idle);

  // burst length picked at the command edge
  assign chop_now = (i_burst_mode == `DWB_BL_CHOP4) ||
    (i_burst_mode == `DWB_BL_OTF && !s_a[`DWB_A12]);
  assign beats = chop_r ? `DWB_BEATS_CHOP : `DWB_BEATS_FULL;

  // beat slot relative to the first data edge
  assign slot = cnt_r - wl_r;

  // mask pin acts only on x8/x16 with inversion off
  assign mask_on = MASK_OK & i_mask_enable & !i_bus_inversion;

  // command capture and burst slot counting
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= dwb_d_idle;
      cnt_r <= '0;
      wl_r <= '0;
      bank_r <= '0;
      col_r <= '0;
      ap_r <= 1'b0;
      chop_r <= 1'b0;
    end else begin
      case (st_r)
        dwb_d_idle: begin
          if (cmd_hit) begin
            st_r <= dwb_d_burst;
            cnt_r <= 6'h01;
            wl_r <= 6'(i_additive_latency) + 6'(i_column_write_latency);
            bank_r <= s_ba;
            col_r <= s_a[9:0];
            ap_r <= s_a[`DWB_A10];
            chop_r <= chop_now;
          end
        end
        dwb_d_burst: begin
          if (rise) begin
            cnt_r <= cnt_r + 6'h01;
            // a chopped burst still runs all eight slots
            if (cnt_r >= wl_r && slot == `DWB_LAST_SLOT) begin
              st_r <= dwb_d_idle;
            end
          end
        end
        default: st_r <= dwb_d_idle;
      endcase
    end
  end

  // data capture; strobes beyond the burst length are ignored
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wr_valid <= 1'b0;
      o_wr_bank <= '0;
      o_wr_col <= '0;
      o_wr_data <= '0;
      o_wr_lane_en <= '0;
    end else begin
      o_wr_valid <= 1'b0;
      if (st_r == dwb_d_burst && rise && cnt_r >= wl_r && slot < 6'(beats) && s_dqs) begin
        o_wr_valid <= 1'b1;
        o_wr_bank <= bank_r;
        o_wr_col <= col_r + 10'(slot);
        o_wr_data <= s_dq;
        // low mask bit drops the lane, high stores it as received
        o_wr_lane_en <= mask_on ? s_dm_n : '1;
      end
    end
  end

  // bank state and automatic precharge at burst end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_precharge <= 1'b0;
      o_precharge_bank <= '0;
      o_bank_open <= '0;
    end else begin
      o_precharge <= 1'b0;
      if (cmd_hit) begin
        o_bank_open[s_ba] <= 1'b1;
      end
      if (st_r == dwb_d_burst && rise && cnt_r >= wl_r &&
          slot == `DWB_LAST_SLOT && ap_r) begin
        o_precharge <= 1'b1;
        o_precharge_bank <= bank_r;
        o_bank_open[bank_r] <= 1'b0;
      end
    end
  end

  // mode and status outputs
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_burst_chop <= 1'b0;
      o_mask_active <= 1'b0;
      o_crc_active <= 1'b0;
      o_crc_persistent <= 1'b0;
      o_die_term <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_burst_chop <= chop_r;
      o_mask_active <= mask_on;
      o_crc_active <= i_crc_enable;
      o_crc_persistent <= i_crc_enable & i_mask_enable;
      o_die_term <= s_term; // follows the command bus, not the select
      o_busy <= st_r != dwb_d_idle;
    end
  end
endmodule
`default_nettype wire

// [sim/dwb_link_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module dwb_link_monitor #(
  parameter int DQ_W = 8,
  parameter int LANES = 1,
  parameter int WL = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic die_term,
  input wire logic dqs,
  input wire logic [13:0] a,
  input wire logic [1:0] ba,
  input wire logic [DQ_W-1:0] dq,
  input wire logic [LANES-1:0] dm_n
);
  localparam int REC_MIN = 7;
  logic ck_q;
  logic edge_w;
  logic [4:0] gap_r;
  logic [3:0] beats_r;
  logic [4:0] wl_r;
  logic armed_r;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  // rising link clock edge seen in the system domain
  assign edge_w = ck & ~ck_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= ck;
    end
  end
  // link cycles since the last data beat, saturating
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_r <= 5'h1f;
    end else if (edge_w) begin
      gap_r <= dqs ? 5'h00 : ((gap_r == 5'h1f) ? gap_r : gap_r + 5'h01);
    end
  end
  // beats counted in the running burst
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      beats_r <= 4'h0;
    end else if (edge_w) begin
      beats_r <= dqs ? beats_r + 4'h1 : 4'h0;
    end
  end
  // link cycles from the command edge to the first beat
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wl_r <= 5'h00;
      armed_r <= 1'b0;
    end else if (edge_w && !wr_n) begin
      wl_r <= 5'h00;
      armed_r <= 1'b1;
    end else if (edge_w) begin
      wl_r <= wl_r + 5'h01;
      armed_r <= armed_r & ~dqs;
    end
  end
  chk_ck_half_period: assert property (
    $rose(ck) |-> ck[*4] ##1 !ck[*4]) else $error("link clock halves not four cycles");
  chk_cmd_one_link: assert property (
    $fell(wr_n) |-> !wr_n[*8] ##1 wr_n) else $error("command not one link cycle");
  chk_term_with_cmd: assert property (
    die_term == !wr_n) else $error("termination not aligned to command");
  chk_fall_edge_only: assert property (
    !$stable({cs_n, wr_n, die_term, dqs, a, ba, dq, dm_n}) |-> $fell(ck))
    else $error("link output moved off the falling clock");
  chk_write_delay: assert property (
    edge_w && dqs && armed_r |-> wl_r == 5'(WL - 1)) else $error("first beat off write delay");
  chk_beat_count: assert property (
    edge_w && !dqs && beats_r != 4'h0 |-> beats_r == 4'h4 || beats_r == 4'h8)
    else $error("burst beat count not four or eight");
  chk_recovery_gap: assert property (
    edge_w && !wr_n |-> gap_r >= 5'(REC_MIN)) else $error("command inside recovery");
  chk_no_cmd_burst: assert property (
    !wr_n |-> !dqs) else $error("command during data beats");
endmodule
`default_nettype wire

// [sim/dram_write_burst_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dwb_consts.svh"
module dram_write_burst_control_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_q;
  logic wb_ack;
  logic [31:0] dcfg = 32'h0000_0a00;
  logic dll = 1'b1;
  logic wv, pre, chop, mact, cact, cper, busy, dterm;
  logic [9:0] col;
  logic [7:0] wd;
  logic [0:0] lane;
  logic [1:0] pbank, pb_last, wbank;
  logic [3:0] bopen;
  logic [20:0] wq[$];
  logic [31:0] rd;
  int n_errors = 0;
  int cmp_count = 0;
  int n_pre = 0;
  int n_term = 0;
  int fifo_lvl = 0;
  int push_pos = 0;
  int pop_pos = 0;
  dwb_link_if dwb_link_if_i ();
  dwb_ctl dwb_ctl_i (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(wb_q),
    .o_wb_ack(wb_ack), .link(dwb_link_if_i.ctl));
  dwb_dram dwb_dram_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .link(dwb_link_if_i.dram), .i_burst_mode(dcfg[1:0]), .i_column_write_latency(dcfg[11:8]),
    .i_additive_latency(dcfg[16:12]), .i_cmd_latency(dcfg[23:20]), .i_mask_enable(dcfg[2]),
    .i_bus_inversion(dcfg[3]), .i_crc_enable(dcfg[4]), .i_dll_locked(dll), .o_wr_valid(wv),
    .o_wr_bank(wbank), .o_wr_col(col), .o_wr_data(wd), .o_wr_lane_en(lane), .o_precharge(pre),
    .o_precharge_bank(pbank), .o_bank_open(bopen), .o_burst_chop(chop), .o_mask_active(mact),
    .o_crc_active(cact), .o_crc_persistent(cper), .o_die_term(dterm), .o_busy(busy));
  dwb_link_monitor dwb_link_monitor_i (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .ck(dwb_link_if_i.ck), .cs_n(dwb_link_if_i.cs_n),
    .wr_n(dwb_link_if_i.wr_n), .die_term(dwb_link_if_i.die_term), .dqs(dwb_link_if_i.dqs),
    .a(dwb_link_if_i.a), .ba(dwb_link_if_i.ba), .dq(dwb_link_if_i.dq),
    .dm_n(dwb_link_if_i.dm_n));
  // system clock
  always #(`DWB_SYS_NS / 2) i_sys_clk = ~i_sys_clk;
  // record stored beats and precharges at the device
  always @(posedge i_sys_clk) begin
    if (wv === 1'b1) begin
      wq.push_back({wbank, lane, col, wd});
    end
    if (dterm === 1'b1) begin
      n_term++;
    end
    if (pre === 1'b1) begin
      n_pre++;
      pb_last = pbank;
    end
  end
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // one classic cycle, held until ack is seen
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    // ack and read data are taken at the same rising edge
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 500);
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 500) begin
      n_errors++;
      test_done();
    end
  endtask
  // program the controller and mirror the setting at the device
  task automatic set_cfg(input logic [31:0] v);
    wb_cycle(1'b1, `DWB_OFS_CFG, v, rd);
    wb_cycle(1'b0, `DWB_OFS_CFG, 32'h0, rd);
    check("cfg", v, rd);
    dcfg <= v;
    // device mode outputs are registered, let them follow the new setting
    repeat (2) @(posedge i_sys_clk);
  endtask
  // push beats, issue one command, wait for idle, compare stored beats
  task automatic burst(input logic [13:0] adr, input logic [1:0] bank, input int push,
    input int len, input int nexp, input logic [7:0] drop, input logic err);
    int i;
    wq.delete();
    n_term = 0;
    for (i = 0; i < push; i++) begin
      wb_cycle(1'b1, `DWB_OFS_DAT, {23'h0, ~drop[i[2:0]], 8'h30 + push_pos[7:0]}, rd);
      push_pos++;
    end
    fifo_lvl += push;
    wb_cycle(1'b0, `DWB_OFS_STAT, 32'h0, rd);
    check("fifo count", fifo_lvl, {27'h0, rd[12:8]});
    wb_cycle(1'b1, `DWB_OFS_CMD, {14'h0, bank, 2'h0, adr}, rd);
    i = 0;
    do begin
      wb_cycle(1'b0, `DWB_OFS_STAT, 32'h0, rd);
      i++;
    end while (rd[0] !== 1'b0 && i < 300);
    check("idle", 32'h0, {31'h0, rd[0]});
    if (rd[0] !== 1'b0) begin
      test_done();
    end
    check("err", 32'(err), {31'h0, rd[1]});
    if (err) begin
      wb_cycle(1'b1, `DWB_OFS_STAT, 32'h2, rd);
    end
    fifo_lvl -= len;
    check("beats", nexp, wq.size());
    for (i = 0; i < wq.size() && i < nexp; i++) begin
      check("beat", {11'h0, bank, ~drop[i[2:0]], adr[9:0] + 10'(i),
        8'h30 + pop_pos[7:0] + i[7:0]}, {11'h0, wq[i]});
    end
    pop_pos += len;
    check("term", err ? 32'h0 : 32'h8, n_term);
    check("busy", 32'h0, 32'(busy));
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    wb_cycle(1'b0, `DWB_OFS_CFG, 32'h0, rd);
    check("cfg reset", `DWB_CFG_RST, rd);
    wb_cycle(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    wb_sel <= 4'h3;
    wb_cycle(1'b1, `DWB_OFS_CFG, 32'h0, rd);
    wb_sel <= 4'hf;
    wb_cycle(1'b0, `DWB_OFS_CFG, 32'h0, rd);
    check("part write", `DWB_CFG_RST, rd);
    // fill the buffer to sixteen, then drain with two plain writes
    burst(14'h0020, 2'h1, 16, 8, 8, 8'h00, 1'b0);
    burst(14'h0040, 2'h2, 0, 8, 8, 8'h00, 1'b0);
    check("open", 32'h6, 32'(bopen));
    check("no pre", 32'h0, n_pre);
    set_cfg(32'h0000_0a01);
    burst(14'h0100, 2'h0, 4, 4, 4, 8'h00, 1'b0);
    check("chop", 32'h1, 32'(chop));
    burst(14'h1100, 2'h0, 8, 8, 8, 8'h00, 1'b0);
    check("full", 32'h0, 32'(chop));
    set_cfg(32'h0000_0a02);
    burst(14'h1200, 2'h0, 4, 4, 4, 8'h00, 1'b0);
    set_cfg(32'h0000_0a14);
    check("mask", 32'h1, 32'(mact));
    check("crc", 32'h1, 32'(cact));
    check("persist", 32'h1, 32'(cper));
    burst(14'h0400, 2'h3, 8, 8, 8, 8'h24, 1'b0);
    check("pre", 32'h1, n_pre);
    check("pre bank", 32'h3, 32'(pb_last));
    check("closed", 32'h0, 32'(bopen[3]));
    set_cfg(32'h0000_0a10);
    check("nonpersist", 32'h0, 32'(cper));
    set_cfg(32'h0000_0a0c);
    check("mask inv", 32'h0, 32'(mact));
    burst(14'h0000, 2'h0, 0, 0, 0, 8'h00, 1'b1);
    set_cfg(32'h0000_0920);
    burst(14'h0000, 2'h0, 0, 0, 0, 8'h00, 1'b1);
    set_cfg(32'h0000_0a20);
    burst(14'h0200, 2'h0, 8, 8, 8, 8'h00, 1'b0);
    dll <= 1'b0;
    burst(14'h0300, 2'h0, 8, 8, 0, 8'h00, 1'b0);
    dll <= 1'b1;
    set_cfg(32'h0030_0a00);
    burst(14'h0380, 2'h1, 8, 8, 8, 8'h00, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
